// file: pkg/tap_pkg.sv
// Shared constants and types for the boundary-scan test access port.
package tap_pkg;

  // Register lengths.
  localparam int IR_LEN  = 4;
  localparam int ID_LEN  = 32;
  localparam int BSR_LEN = 16;

  // Instruction codes.
  localparam logic [IR_LEN-1:0] OP_EXTEST = 4'h0;
  localparam logic [IR_LEN-1:0] OP_SAMPLE = 4'h1;
  localparam logic [IR_LEN-1:0] OP_IDCODE = 4'h2;
  localparam logic [IR_LEN-1:0] OP_HIGHZ  = 4'h3;
  localparam logic [IR_LEN-1:0] OP_BYPASS = 4'hf;

  // Fixed pattern loaded in the instruction capture state.
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;

  // Identification word fields; the values are arbitrary.
  localparam int               ID_VER_LSB  = 28;
  localparam int               ID_PART_LSB = 12;
  localparam int               ID_MFR_LSB  = 1;
  localparam logic [3:0]       ID_VERSION  = 4'h1;
  localparam logic [15:0]      ID_PART     = 16'h5a3c;
  localparam logic [10:0]      ID_MFR      = 11'h0a5;
  localparam logic [ID_LEN-1:0] ID_WORD    = {ID_VERSION, ID_PART, ID_MFR, 1'b1};

  // Reset values.
  localparam logic [IR_LEN-1:0]  IR_RESET  = OP_IDCODE;
  localparam logic [BSR_LEN-1:0] BSR_RESET = 16'h0000;

  // Controller states.
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_t;

  // Data register that sits between the serial pins.
  typedef enum logic [1:0] {DR_BYPASS, DR_BSR, DR_ID} dr_sel_t;

endpackage

// file: pkg/tap_ctl_if.sv
// Carrier between the port core and its state machine.
`timescale 1ns/10ps
interface tap_ctl_if;
  logic                tckRise; // One-cycle pulse on a test-clock rising edge.
  logic                tmsLvl;  // Filtered mode-select level.
  tap_pkg::tap_state_t state;   // Current controller state.

  modport fsm  (input tckRise, input tmsLvl, output state);
  modport core (output tckRise, output tmsLvl, input state);
endinterface

// file: design/tap_fsm.sv
// Sixteen-state test access port controller.
`timescale 1ns/10ps
module tap_fsm (
  input wire logic mclk,
  input wire logic rstTapN,
  tap_ctl_if.fsm   ctl
);

  // Next state from the present state and the sampled mode select.
  function automatic tap_pkg::tap_state_t nextState(input tap_pkg::tap_state_t s, input logic m);
    unique case (s)
      tap_pkg::TLR:    nextState = m ? tap_pkg::TLR    : tap_pkg::RTI;
      tap_pkg::RTI:    nextState = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_DR: nextState = m ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
      tap_pkg::CAP_DR: nextState = m ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
      tap_pkg::SH_DR:  nextState = m ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
      tap_pkg::EX1_DR: nextState = m ? tap_pkg::UPD_DR : tap_pkg::PA_DR;
      tap_pkg::PA_DR:  nextState = m ? tap_pkg::EX2_DR : tap_pkg::PA_DR;
      tap_pkg::EX2_DR: nextState = m ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
      tap_pkg::UPD_DR: nextState = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_IR: nextState = m ? tap_pkg::TLR    : tap_pkg::CAP_IR;
      tap_pkg::CAP_IR: nextState = m ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
      tap_pkg::SH_IR:  nextState = m ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
      tap_pkg::EX1_IR: nextState = m ? tap_pkg::UPD_IR : tap_pkg::PA_IR;
      tap_pkg::PA_IR:  nextState = m ? tap_pkg::EX2_IR : tap_pkg::PA_IR;
      tap_pkg::EX2_IR: nextState = m ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
      tap_pkg::UPD_IR: nextState = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
    endcase
  endfunction

  // The state moves only on a test-clock rising edge, steered by the sampled mode select.
  // Any path of five ones ends in the reset state, whatever the start.
  always_ff @(posedge mclk or negedge rstTapN)
  begin
    if (!rstTapN)
    begin
      ctl.state <= tap_pkg::TLR;
    end
    else if (ctl.tckRise)
    begin
      ctl.state <= nextState(ctl.state, ctl.tmsLvl);
    end
  end

endmodule // tap_fsm

// file: design/boundary_scan_tap.sv
// Boundary-scan test access port core with sampled test pins.
`timescale 1ns/10ps
module boundary_scan_tap (
  input  wire logic                         mclk,
  input  wire logic                         nrst,
  input  wire logic                         tck,
  input  wire logic                         tms,
  input  wire logic                         tdi,
  input  wire logic                         ntrst,
  input  wire logic [tap_pkg::BSR_LEN-1:0]  bsrSample,
  output logic                              tdo,
  output logic                              tdoOe,
  output logic [tap_pkg::BSR_LEN-1:0]       bsrDrive,
  output logic                              bsrDriveEn,
  output logic                              pinsDisable,
  output logic                              fifoEnable,
  output logic [3:0]                        tapState
);

  // Select the data register for an instruction.
  // Every code without its own function falls to bypass.
  function automatic tap_pkg::dr_sel_t drSelect(input logic [tap_pkg::IR_LEN-1:0] op);
    unique case (op)
      tap_pkg::OP_EXTEST: drSelect = tap_pkg::DR_BSR;
      tap_pkg::OP_SAMPLE: drSelect = tap_pkg::DR_BSR;
      tap_pkg::OP_IDCODE: drSelect = tap_pkg::DR_ID;
      tap_pkg::OP_HIGHZ:  drSelect = tap_pkg::DR_BYPASS;
      default:            drSelect = tap_pkg::DR_BYPASS;
    endcase
  endfunction

  // Pin samplers, bit order: test clock, mode select, data in, test reset.
  logic [3:0] pinS1_q;   // First stage, read only by the second.
  logic [3:0] pinS2_q;   // Second stage.
  logic [3:0] pinS3_q;   // Third stage.
  logic [3:0] pinLvl_q;  // Accepted levels.
  logic [3:0] pinLvl_d;  // Levels accepted this cycle.

  // Reset of the controller: either reset asserts it at once.
  logic       tapRstRawN; // Raw combined reset.
  logic [1:0] tapRst_q;   // Release synchroniser.
  logic       tapRstN;    // Reset used by the test logic.

  // Test-clock edge pulses.
  logic tckRise;
  logic tckFall;

  // Controller carrier.
  tap_ctl_if ctl ();

  // Shift stages and held values.
  logic [tap_pkg::IR_LEN-1:0]  irShift_q;  // Instruction shift stages.
  logic [tap_pkg::IR_LEN-1:0]  irCur_q;    // Current instruction.
  logic                        bypass_q;   // Bypass stage.
  logic [tap_pkg::ID_LEN-1:0]  idShift_q;  // Identification shift stages.
  logic [tap_pkg::BSR_LEN-1:0] bsrShift_q; // Boundary shift stages.
  logic [tap_pkg::BSR_LEN-1:0] bsrHold_q;  // Boundary update latch.
  logic                        tdo_q;
  logic                        tdoOe_q;
  logic                        extest_q;
  logic                        highz_q;
  logic                        fifoEn_q;
  logic                        resetSeen_q; // Controller has been reset by the tester.
  tap_pkg::dr_sel_t            drSel;       // Register picked by the current instruction.

  // The combined reset acts at once but is released on the clock, so the
  // controller never sees a release close to an edge.
  assign tapRstRawN = nrst & ntrst;

  // Reset release synchroniser; the flops take only constants under reset.
  always_ff @(posedge mclk or negedge tapRstRawN)
  begin
    if (!tapRstRawN)
    begin
      tapRst_q <= 2'h0;
    end
    else
    begin
      tapRst_q <= {tapRst_q[0], 1'b1};
    end
  end

  assign tapRstN = tapRst_q[1];

  // Three-stage sampling of every pin from the tester's domain.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pinS1_q <= 4'h8;
      pinS2_q <= 4'h8;
      pinS3_q <= 4'h8;
    end
    else
    begin
      pinS1_q <= {ntrst, tdi, tms, tck};
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
    end
  end

  // A level is accepted only when the second and third stages agree.
  // This rejects single-cycle glitches at the cost of two cycles of delay.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      pinLvl_d[i] = (pinS2_q[i] == pinS3_q[i]) ? pinS3_q[i] : pinLvl_q[i];
    end
  end

  // Accepted pin levels.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pinLvl_q <= 4'h8;
    end
    else
    begin
      pinLvl_q <= pinLvl_d;
    end
  end

  // Edges of the accepted test clock.
  assign tckRise = pinLvl_d[0] & ~pinLvl_q[0];
  assign tckFall = ~pinLvl_d[0] & pinLvl_q[0];

  // Feed the controller; mode select is taken as accepted before the edge.
  assign ctl.tckRise = tckRise;
  assign ctl.tmsLvl  = pinLvl_q[1];

  // Controller state machine.
  tap_fsm fsm (
    .mclk    (mclk),
    .rstTapN (tapRstN),
    .ctl     (ctl)
  );

  // The data register in the path follows the current instruction.
  assign drSel = drSelect(irCur_q);

  // Instruction shift stages: load the fixed pattern, then shift with
  // the lowest bit nearest the serial output.
  always_ff @(posedge mclk or negedge tapRstN)
  begin
    if (!tapRstN)
    begin
      irShift_q <= tap_pkg::IR_CAPTURE;
    end
    else if (tckRise)
    begin
      if (ctl.state == tap_pkg::CAP_IR)
      begin
        irShift_q <= tap_pkg::IR_CAPTURE;
      end
      else if (ctl.state == tap_pkg::SH_IR)
      begin
        irShift_q <= {pinLvl_q[2], irShift_q[tap_pkg::IR_LEN-1:1]};
      end
    end
  end

  // Current instruction: taken on the falling edge in Update-IR, and
  // forced back to the identification code while in reset state.
  always_ff @(posedge mclk or negedge tapRstN)
  begin
    if (!tapRstN)
    begin
      irCur_q <= tap_pkg::IR_RESET;
    end
    else if (ctl.state == tap_pkg::TLR)
    begin
      irCur_q <= tap_pkg::IR_RESET;
    end
    else if (tckFall && ctl.state == tap_pkg::UPD_IR)
    begin
      irCur_q <= irShift_q;
    end
  end

  // Bypass stage: zero on capture, one stage between the pins on shift.
  // It never touches functional outputs.
  always_ff @(posedge mclk or negedge tapRstN)
  begin
    if (!tapRstN)
    begin
      bypass_q <= 1'b0;
    end
    else if (tckRise && drSel == tap_pkg::DR_BYPASS)
    begin
      if (ctl.state == tap_pkg::CAP_DR)
      begin
        bypass_q <= 1'b0;
      end
      else if (ctl.state == tap_pkg::SH_DR)
      begin
        bypass_q <= pinLvl_q[2];
      end
    end
  end

  // Identification stages: the fixed word is reloaded on every capture,
  // so shifted-in data can never change what is read next time.
  always_ff @(posedge mclk or negedge tapRstN)
  begin
    if (!tapRstN)
    begin
      idShift_q <= tap_pkg::ID_WORD;
    end
    else if (tckRise && drSel == tap_pkg::DR_ID)
    begin
      if (ctl.state == tap_pkg::CAP_DR)
      begin
        idShift_q <= tap_pkg::ID_WORD;
      end
      else if (ctl.state == tap_pkg::SH_DR)
      begin
        idShift_q <= {pinLvl_q[2], idShift_q[tap_pkg::ID_LEN-1:1]};
      end
    end
  end

  // Boundary stages: capture the pin image, then shift.
  always_ff @(posedge mclk or negedge tapRstN)
  begin
    if (!tapRstN)
    begin
      bsrShift_q <= tap_pkg::BSR_RESET;
    end
    else if (tckRise && drSel == tap_pkg::DR_BSR)
    begin
      if (ctl.state == tap_pkg::CAP_DR)
      begin
        bsrShift_q <= bsrSample;
      end
      else if (ctl.state == tap_pkg::SH_DR)
      begin
        bsrShift_q <= {pinLvl_q[2], bsrShift_q[tap_pkg::BSR_LEN-1:1]};
      end
    end
  end

  // Boundary update latch, loaded on the falling edge in Update-DR.
  // Preload under sample lands here before an external test starts.
  always_ff @(posedge mclk or negedge tapRstN)
  begin
    if (!tapRstN)
    begin
      bsrHold_q <= tap_pkg::BSR_RESET;
    end
    else if (tckFall && ctl.state == tap_pkg::UPD_DR && drSel == tap_pkg::DR_BSR)
    begin
      bsrHold_q <= bsrShift_q;
    end
  end

  // Serial output changes on the falling edge, so the tester can sample
  // it on the next rising edge; it is enabled only in the shift states.
  always_ff @(posedge mclk or negedge tapRstN)
  begin
    if (!tapRstN)
    begin
      tdo_q   <= 1'b0;
      tdoOe_q <= 1'b0;
    end
    else if (tckFall)
    begin
      if (ctl.state == tap_pkg::SH_IR)
      begin
        tdo_q   <= irShift_q[0];
        tdoOe_q <= 1'b1;
      end
      else if (ctl.state == tap_pkg::SH_DR)
      begin
        tdoOe_q <= 1'b1;
        unique case (drSel)
          tap_pkg::DR_BSR: tdo_q <= bsrShift_q[0];
          tap_pkg::DR_ID:  tdo_q <= idShift_q[0];
          default:         tdo_q <= bypass_q;
        endcase
      end
      else
      begin
        tdoOe_q <= 1'b0;
      end
    end
  end

  // The tester has reset the controller once it has held the reset pin
  // low or an edge with mode select high has moved it into, or kept it in,
  // reset state. Only the chip reset clears this, as nothing else resets it.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      resetSeen_q <= 1'b0;
    end
    else if (!pinLvl_q[3] || (tckRise && pinLvl_q[1]
             && (ctl.state == tap_pkg::TLR || ctl.state == tap_pkg::SEL_IR)))
    begin
      resetSeen_q <= 1'b1;
    end
  end

  // Functional controls. Test logic wins over the memory: until the
  // controller is reset, and during external test or high impedance,
  // the memory is held out of normal use. No instruction here runs a
  // self test, so Run-Test-Idle leaves these untouched.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      extest_q <= 1'b0;
      highz_q  <= 1'b0;
      fifoEn_q <= 1'b0;
    end
    else
    begin
      extest_q <= resetSeen_q && irCur_q == tap_pkg::OP_EXTEST && ctl.state != tap_pkg::TLR;
      highz_q  <= resetSeen_q && irCur_q == tap_pkg::OP_HIGHZ && ctl.state != tap_pkg::TLR;
      fifoEn_q <= resetSeen_q && irCur_q != tap_pkg::OP_EXTEST
                  && irCur_q != tap_pkg::OP_HIGHZ;
    end
  end

  // All outputs come straight from flops.
  assign tdo         = tdo_q;
  assign tdoOe       = tdoOe_q;
  assign bsrDrive    = bsrHold_q;
  assign bsrDriveEn  = extest_q;
  assign pinsDisable = highz_q;
  assign fifoEnable  = fifoEn_q;
  assign tapState    = ctl.state;

endmodule // boundary_scan_tap

// file: verif/tap_monitor.sv
// Assertion checker for the test access port, bound to its top module.
`timescale 1ns/10ps
module tap_monitor (
  input wire logic                        mclk,
  input wire logic                        nrst,
  input wire logic                        tck,
  input wire logic                        tms,
  input wire logic                        ntrst,
  input wire logic                        tdoOe,
  input wire logic [tap_pkg::BSR_LEN-1:0] bsrDrive,
  input wire logic                        bsrDriveEn,
  input wire logic                        pinsDisable,
  input wire logic                        fifoEnable,
  input wire logic [3:0]                  tapState
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // Successor of a controller state for a given mode-select level.
  function automatic logic [3:0] nxt(input logic [3:0] s, input logic m);
    case (s)
      4'h0: nxt = m ? 4'h0 : 4'h1;
      4'h1, 4'h8, 4'hf: nxt = m ? 4'h2 : 4'h1;
      4'h2: nxt = m ? 4'h9 : 4'h3;
      4'h3, 4'h4: nxt = m ? 4'h5 : 4'h4;
      4'h5: nxt = m ? 4'h8 : 4'h6;
      4'h6: nxt = m ? 4'h7 : 4'h6;
      4'h7: nxt = m ? 4'h8 : 4'h4;
      4'h9: nxt = m ? 4'h0 : 4'ha;
      4'ha, 4'hb: nxt = m ? 4'hc : 4'hb;
      4'hc: nxt = m ? 4'hf : 4'hd;
      4'hd: nxt = m ? 4'he : 4'hd;
      default: nxt = m ? 4'hf : 4'hb;
    endcase
  endfunction

  // Mode select is steady for many cycles around a test-clock rise, so four cycles back is safe.
  property p_next_state;
    $changed(tapState) && ntrst && $past(ntrst) |-> tapState == nxt($past(tapState), $past(tms, 4));
  endproperty
  a_next_state: assert property (p_next_state) else $error("controller took a wrong branch");

  property p_tck_edge;
    $changed(tapState) && ntrst && $past(ntrst) |-> $past(tck, 2) && !$past(tck, 12);
  endproperty
  a_tck_edge: assert property (p_tck_edge) else $error("state moved without a test-clock rise");

  property p_trst;
    !ntrst |=> tapState == 4'h0 && !tdoOe;
  endproperty
  a_trst: assert property (p_trst) else $error("test reset pin did not force reset state");

  property p_tlr_quiet;
    (tapState == 4'h0) [*4] |-> !bsrDriveEn && !pinsDisable && !tdoOe;
  endproperty
  a_tlr_quiet: assert property (p_tlr_quiet) else $error("test logic active in reset state");

  property p_oe_shift;
    $rose(tdoOe) |-> tapState == 4'h4 || tapState == 4'hb;
  endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("serial output enabled outside shift");

  property p_highz;
    pinsDisable |-> !fifoEnable && !bsrDriveEn;
  endproperty
  a_highz: assert property (p_highz) else $error("high impedance mode left memory running");

  property p_extest;
    bsrDriveEn |-> !fifoEnable;
  endproperty
  a_extest: assert property (p_extest) else $error("boundary drive while memory runs");

  property p_bsr_update;
    $changed(bsrDrive) && ntrst && $past(ntrst) |-> tapState == 4'h8;
  endproperty
  a_bsr_update: assert property (p_bsr_update) else $error("boundary latch moved outside update");
endmodule // tap_monitor

bind boundary_scan_tap tap_monitor tap_monitor_i (.mclk(mclk), .nrst(nrst), .tck(tck), .tms(tms), .ntrst(ntrst),
  .tdoOe(tdoOe), .bsrDrive(bsrDrive), .bsrDriveEn(bsrDriveEn), .pinsDisable(pinsDisable),
  .fifoEnable(fifoEnable), .tapState(tapState));

// file: verif/jtag_tester.sv
// Behavioural boundary-scan tester that drives the test pins.
`timescale 1ns/10ps
module jtag_tester (
  input  wire logic mclk,
  input  wire logic tdo,
  input  wire logic tdoOe,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      ntrst
);
  // Pins rest with the clock low and the test reset released.
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    ntrst = 1'b1;
  end

  // One test-clock period; the output is sampled late in the low half, where it has settled.
  // A released output reads back inverted, so a bit taken while it is not driven cannot pass.
  task automatic step(input logic m, input logic d, output logic o);
    @(negedge mclk);
    tms = m;
    tdi = d;
    repeat (15) @(negedge mclk);
    o = tdoOe ? tdo : ~tdo;
    tck = 1'b1;
    repeat (16) @(negedge mclk);
    tck = 1'b0;
  endtask

  // The device does not reset itself, so the tester does it before any use.
  task automatic tms_reset();
    logic o;
    repeat (5) step(1'b1, ~tdi, o);
  endtask

  // Held for eight cycles so the sampled level is also seen.
  task automatic pulse_trst();
    @(negedge mclk);
    ntrst = 1'b0;
    repeat (8) @(negedge mclk);
    ntrst = 1'b1;
    repeat (6) @(negedge mclk);
  endtask

  // Scan n bits from idle; with 0 <= pause < n-1 the scan rests in the pause state after that bit.
  task automatic scan(input logic ir, input int n, input logic [47:0] din, input int pause,
                      output logic [47:0] dout);
    logic o;
    dout = '0;
    step(1'b1, ~tdi, o);
    if (ir)
      step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
    step(1'b0, ~tdi, o);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1 || i == pause, din[i], dout[i]);
      if (i == pause && i != n - 1)
      begin
        step(1'b0, ~tdi, o);
        step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
      end
    end
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask
endmodule // jtag_tester

// file: verif/tb.sv
// Self-checking testbench for the boundary-scan test access port.
`timescale 1ns/10ps
module tb;
  localparam logic [31:0] ID_EXP = {tap_pkg::ID_VERSION, tap_pkg::ID_PART, tap_pkg::ID_MFR, 1'b1};
  localparam logic [47:0] PAT    = 48'h9c3a_5e71_b2d4;
  localparam logic [3:0]  CODES [6] = '{tap_pkg::OP_BYPASS, tap_pkg::OP_IDCODE, tap_pkg::OP_SAMPLE,
                                        tap_pkg::OP_HIGHZ, 4'h5, tap_pkg::OP_EXTEST};

  logic                        mclk;        // System clock.
  logic                        nrst;        // Chip reset.
  logic                        tck;         // Test pins from the tester.
  logic                        tms;
  logic                        tdi;
  logic                        ntrst;
  logic [tap_pkg::BSR_LEN-1:0] bsrSample;   // Boundary image seen at capture.
  logic                        tdo;
  logic                        tdoOe;
  logic [tap_pkg::BSR_LEN-1:0] bsrDrive;
  logic                        bsrDriveEn;
  logic                        pinsDisable;
  logic                        fifoEnable;
  logic [3:0]                  tapState;
  int                          n_mismatch;
  int                          samples_checked;

  boundary_scan_tap boundary_scan_tap_i (.mclk(mclk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi),
    .ntrst(ntrst), .bsrSample(bsrSample), .tdo(tdo), .tdoOe(tdoOe), .bsrDrive(bsrDrive),
    .bsrDriveEn(bsrDriveEn), .pinsDisable(pinsDisable), .fifoEnable(fifoEnable), .tapState(tapState));

  jtag_tester jtag_tester_i (.mclk(mclk), .tdo(tdo), .tdoOe(tdoOe), .tck(tck), .tms(tms), .tdi(tdi),
    .ntrst(ntrst));

  // 200 MHz system clock.
  always #2.5 mclk = ~mclk;

  // Compare one result and count it.
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bits back from a 48-bit data scan of a register of length len that captured cap.
  function automatic logic [47:0] expect_dr(input int len, input logic [31:0] cap, input logic [47:0] din);
    expect_dr = din << len;
    for (int i = 0; i < len; i++)
      expect_dr[i] = cap[i];
  endfunction

  // Single exit point of the run.
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence of scans.
  initial
  begin
    logic [47:0] res;
    logic [47:0] din;
    logic [31:0] cap;
    logic        o;
    logic        ext;
    logic        hz;
    int          len;
    mclk = 1'b0;
    nrst = 1'b0;
    bsrSample = 16'hc3a5;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    repeat (6) @(negedge mclk);
    chk({47'h0, fifoEnable}, 48'h0);
    // Walk into shift-data, then escape with five high mode-select rises.
    jtag_tester_i.step(1'b0, 1'b0, o);
    jtag_tester_i.step(1'b1, 1'b1, o);
    jtag_tester_i.step(1'b0, 1'b0, o);
    jtag_tester_i.step(1'b0, 1'b1, o);
    jtag_tester_i.tms_reset();
    repeat (4) @(negedge mclk);
    chk({43'h0, tapState, fifoEnable}, {43'h0, 4'h0, 1'b1});
    jtag_tester_i.step(1'b0, 1'b0, o);
    jtag_tester_i.scan(1'b0, 48, PAT, -1, res);
    chk(res, expect_dr(32, ID_EXP, PAT));
    // Every decoded code plus one undefined code, each with a paused data scan.
    foreach (CODES[k])
    begin
      jtag_tester_i.scan(1'b1, 4, {44'h0, CODES[k]}, 1, res);
      chk({46'h0, res[1:0]}, 48'h1);
      ext = CODES[k] == tap_pkg::OP_EXTEST;
      hz = CODES[k] == tap_pkg::OP_HIGHZ;
      chk({45'h0, bsrDriveEn, pinsDisable, fifoEnable}, {45'h0, ext, hz, !(ext || hz)});
      len = (CODES[k] == tap_pkg::OP_IDCODE) ? 32 : (CODES[k] <= 4'h1) ? tap_pkg::BSR_LEN : 1;
      cap = (len == 32) ? ID_EXP : (len == 1) ? 32'h0 : {16'h0, bsrSample};
      // The top nibble follows the code, so each boundary update leaves a different image.
      din = {CODES[k], PAT[43:0]};
      jtag_tester_i.scan(1'b0, 48, din, 20, res);
      chk(res, expect_dr(len, cap, din));
      if (len == tap_pkg::BSR_LEN)
        chk({32'h0, bsrDrive}, din >> 32);
    end
    // Test reset pin in the middle of a shift.
    jtag_tester_i.step(1'b1, 1'b0, o);
    jtag_tester_i.step(1'b0, 1'b1, o);
    jtag_tester_i.step(1'b0, 1'b0, o);
    jtag_tester_i.step(1'b0, 1'b1, o);
    jtag_tester_i.pulse_trst();
    chk({42'h0, tapState, tdoOe, bsrDriveEn}, 48'h0);
    jtag_tester_i.step(1'b0, 1'b0, o);
    jtag_tester_i.scan(1'b0, 48, ~PAT, -1, res);
    chk(res, expect_dr(32, ID_EXP, ~PAT));
    // Select-instruction branch back to reset.
    repeat (3) jtag_tester_i.step(1'b1, 1'b0, o);
    repeat (4) @(negedge mclk);
    chk({44'h0, tapState}, 48'h0);
    tally_and_finish();
  end

  // Watchdog well beyond the expected run of about 17300 cycles.
  initial
  begin
    #400000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule // tb
